// ===== design/nmb_bridge.sv
`timescale 1ns/100ps
// Function
// - All crossings run in this mapping logic, never via local processor.
// - Carries NuBus-to-Multibus and Multibus-to-NuBus accesses.
// - Buses run apart; coupled only while one targets the other.
// - Colliding NuBus access gets try-again-later; Multibus cycle finishes.
// - Multibus spaces sit in slot space with fixed address correspondence.
// - Memory byte and halfword accesses keep their size on Multibus.
// - Memory word access becomes two halfwords, lower one first.
// - I/O low range accepts all sizes; only word low byte carries data.
// - I/O full range passes byte, halfword and word at full width.
// - Multibus requested and owned before the cycle is driven.
// - One Multibus cycle, two for a word outside the I/O low range, standard handshake.
// - NuBus lock during translation drives Multibus lock.
// - Top ten Multibus address bits pick map entry; bit 23 valid.
// - Multibus lock during conversion keeps NuBus locked until released.
module nmb_bridge
#(
   parameter logic [3:0] SLOT = nmb_pkg::SLOT_RST
)
(
   // Clock and reset
   input  wire logic                          I_CLK_SYS,
   input  wire logic                          I_RST,
   // NuBus slave side (same clock)
   input  wire logic                          I_NB_START,
   input  wire nmb_pkg::nmb_nb_req_t          I_NB_REQ,
   output logic                               O_NB_ACK,
   output logic [1:0]                         O_NB_STAT,
   output logic [31:0]                        O_NB_RDATA,
   // NuBus master side (same clock)
   output logic                               O_NBM_REQ,
   input  wire logic                          I_NBM_GRANT,
   output logic                               O_NBM_START,
   output nmb_pkg::nmb_nb_req_t               O_NBM_REQ_D,
   input  wire logic                          I_NBM_ACK,
   input  wire logic [31:0]                   I_NBM_RDATA,
   // Multibus master side (asynchronous inputs)
   output logic                               O_MB_BREQ,
   input  wire logic                          I_MB_GRANT,
   output logic                               O_MB_BUSY,
   output logic [nmb_pkg::MB_ADR_W-1:0]       O_MB_ADR,
   output logic                               O_MB_BHE,
   output nmb_pkg::nmb_mb_cmd_t               O_MB_CMD,
   output logic                               O_MB_LOCK,
   output logic [15:0]                        O_MB_DAT,
   output logic                               O_MB_DAT_OE,
   input  wire logic [15:0]                   I_MB_DAT,
   input  wire logic                          I_MB_XACK,
   // Multibus slave side (asynchronous inputs)
   input  wire nmb_pkg::nmb_mbs_req_t         I_MBS,
   output logic                               O_MBS_XACK,
   output logic [15:0]                        O_MBS_DAT,
   output logic                               O_MBS_DAT_OE,
   // Map load port from the local processor
   input  wire logic                          I_MAP_WE,
   input  wire logic [nmb_pkg::MAP_IDX_W-1:0] I_MAP_IDX,
   input  wire logic [nmb_pkg::MAP_W-1:0]     I_MAP_DATA
);

   // ****************
   // Types and functions
   // ****************
   typedef enum logic [7:0] {
      S_IDLE   = 8'h01,
      S_NM_ARB = 8'h02,
      S_NM_CMD = 8'h04,
      S_NM_REL = 8'h08,
      S_MN_MAP = 8'h10,
      S_MN_ARB = 8'h20,
      S_MN_CYC = 8'h40,
      S_MN_END = 8'h80
   } nmb_state_t;

   // Pick one byte lane of a 32-bit word
   function automatic logic [7:0] lane8(input logic [31:0] w,
                                        input logic [1:0]  k);
      lane8 = w[{k, 3'h0} +: 8];
   endfunction

   // Pick one half of a 32-bit word
   function automatic logic [15:0] lane16(input logic [31:0] w,
                                          input logic        hi);
      lane16 = hi ? w[31:16] : w[15:0];
   endfunction

   // ****************
   // Declarations
   // ****************
   localparam int SW = $bits(nmb_pkg::nmb_mbs_req_t) + 18;

   nmb_state_t            state_r;
   nmb_pkg::nmb_nb_req_t  req_r;
   logic                  io_r;
   logic                  io_low_r;
   logic                  second_r;
   logic [SW-1:0]         sync1_r;
   logic [SW-1:0]         sync2_r;
   nmb_pkg::nmb_mbs_req_t mbs_s;
   logic                  grant_s;
   logic                  xack_s;
   logic [15:0]           din_s;
   logic [nmb_pkg::MAP_W-1:0] map_q;

   // ****************
   // Synchroniser for Multibus inputs
   // ****************
   // Slave bus and read data synchronised; data settles before XACK
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RST)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= {I_MBS, I_MB_GRANT, I_MB_XACK, I_MB_DAT};
         sync2_r <= sync1_r;
      end
   end

   assign mbs_s   = nmb_pkg::nmb_mbs_req_t'(sync2_r[SW-1:18]);
   assign grant_s = sync2_r[17];
   assign xack_s  = sync2_r[16];
   assign din_s   = sync2_r[15:0];

   // ****************
   // NuBus decode
   // ****************
   // Fixed windows inside this slot
   wire        nb_hit    = I_NB_REQ.addr[31:24]
                           == {nmb_pkg::SLOT_SPACE, SLOT};
   wire [1:0]  nb_win    = I_NB_REQ.addr[nmb_pkg::WIN_MSB -: 2];
   wire        nb_io     = nb_win[1];
   wire        nb_io_low = nb_win == nmb_pkg::WIN_IO_LOW;
   wire        mbs_cmd   = mbs_s.rd | mbs_s.wr;
   // A pending Multibus slave cycle owns the bridge
   wire        nb_take   = I_NB_START & nb_hit;
   wire        collide   = nb_take & ((state_r != S_IDLE) | mbs_cmd);

   // ****************
   // Multibus address and write data for the current half
   // ****************
   wire        is_word = req_r.size == nmb_pkg::SIZE_WORD;
   wire        is_half = req_r.size == nmb_pkg::SIZE_HALF;
   wire [7:0]  wbyte   = io_low_r ? req_r.wdata[7:0]
                                  : lane8(req_r.wdata, req_r.addr[1:0]);
   // Word splits low half first, then high
   wire [15:0] whalf   = lane16(req_r.wdata,
                                is_word ? second_r : req_r.addr[1]);
   wire [22:0] mem_adr = is_word ? {req_r.addr[22:2], second_r, 1'b0}
                       : is_half ? {req_r.addr[22:1], 1'b0}
                                 : req_r.addr[22:0];
   // Low I/O range: one I/O byte per NuBus word
   wire [15:0] io_adr  = io_low_r
                         ? req_r.addr[nmb_pkg::IO_LOW_SH +: 16]
                         : mem_adr[15:0];   // Full range
   wire [23:0] mb_adr  = io_r ? {8'h00, io_adr} : {1'b0, mem_adr};
   wire        mb_byte = io_low_r | (req_r.size == nmb_pkg::SIZE_BYTE);
   // Byte and low I/O range keep byte size, other half and word use both lanes
   wire        mb_bhe  = ~mb_byte | mb_adr[0];
   wire [15:0] mb_wdat = mb_byte ? {wbyte, wbyte} : whalf;
   wire [7:0]  rbyte   = O_MB_ADR[0] ? din_s[15:8] : din_s[7:0];
   wire        last    = ~is_word | io_low_r | second_r;

   // ****************
   // Multibus to NuBus translation
   // ****************
   // Entry index is the top ten address bits
   wire [nmb_pkg::MAP_IDX_W-1:0] map_idx =
      mbs_s.adr[nmb_pkg::MB_ADR_W-1 -: nmb_pkg::MAP_IDX_W];
   wire map_valid = map_q[nmb_pkg::MAP_VALID];
   wire m_half    = mbs_s.bhe & ~mbs_s.adr[0];
   wire [31:0] nbm_addr = {map_q[31-nmb_pkg::PAGE_W:0],
                           mbs_s.adr[nmb_pkg::PAGE_W-1:0]};

   nmb_map_ram
   #(
      .W (nmb_pkg::MAP_W),
      .A (nmb_pkg::MAP_IDX_W)
   )
   u_map
   (
      .i_clk   (I_CLK_SYS),
      .i_we    (I_MAP_WE),
      .i_waddr (I_MAP_IDX),
      .i_wdata (I_MAP_DATA),
      .i_raddr (map_idx),
      .o_rdata (map_q)
   );

   // ****************
   // Bridge sequencer
   // ****************
   // One sequencer for both directions, so the two never overlap
   always_ff @(posedge I_CLK_SYS)
   begin
      if (I_RST)
      begin
         state_r      <= S_IDLE;
         req_r        <= '0;
         io_r         <= 1'b0;
         io_low_r     <= 1'b0;
         second_r     <= 1'b0;
         O_NB_ACK     <= 1'b0;
         O_NB_STAT    <= nmb_pkg::STAT_OK;
         O_NB_RDATA   <= '0;
         O_NBM_REQ    <= 1'b0;
         O_NBM_START  <= 1'b0;
         O_NBM_REQ_D  <= '0;
         O_MB_BREQ    <= 1'b0;
         O_MB_BUSY    <= 1'b0;
         O_MB_ADR     <= '0;
         O_MB_BHE     <= 1'b0;
         O_MB_CMD     <= '0;
         O_MB_LOCK    <= 1'b0;
         O_MB_DAT     <= '0;
         O_MB_DAT_OE  <= 1'b0;
         O_MBS_XACK   <= 1'b0;
         O_MBS_DAT    <= '0;
         O_MBS_DAT_OE <= 1'b0;
      end
      else
      begin
         O_NB_ACK    <= 1'b0;
         O_NBM_START <= 1'b0;
         // Refuse at once, the Multibus side keeps going
         if (collide)
         begin
            O_NB_ACK  <= 1'b1;
            O_NB_STAT <= nmb_pkg::STAT_RETRY;
         end
         // Lock for NuBus master held while Multibus lock stays
         if (!mbs_s.lock && state_r == S_IDLE && O_NBM_REQ_D.lock)
         begin
            O_NBM_REQ        <= 1'b0;
            O_NBM_REQ_D.lock <= 1'b0;
         end
         unique case (state_r)
            S_IDLE:
            begin
               if (nb_take && !collide)
               begin
                  // Start cycle opens the crossing
                  req_r     <= I_NB_REQ;
                  io_r      <= nb_io;
                  io_low_r  <= nb_io_low;
                  second_r  <= 1'b0;
                  O_MB_BREQ <= 1'b1;
                  state_r   <= S_NM_ARB;
               end
               else if (mbs_cmd)
                  state_r <= S_MN_MAP;        // Map read takes a cycle
            end
            S_NM_ARB:
            begin
               // Drive nothing until the bus is ours
               if (grant_s)
               begin
                  O_MB_BUSY   <= 1'b1;
                  O_MB_LOCK   <= req_r.lock;
                  O_MB_ADR    <= mb_adr;
                  O_MB_BHE    <= mb_bhe;
                  O_MB_DAT    <= mb_wdat;
                  O_MB_DAT_OE <= req_r.write;
                  state_r     <= S_NM_CMD;
               end
            end
            S_NM_CMD:
            begin
               // Command a cycle after address, held until XACK
               O_MB_CMD <= '{mem_rd: ~io_r & ~req_r.write,
                             mem_wr: ~io_r &  req_r.write,
                             io_rd:   io_r & ~req_r.write,
                             io_wr:   io_r &  req_r.write};
               if (xack_s && O_MB_CMD != '0)
               begin
                  O_MB_CMD <= '0;
                  if (!req_r.write)
                  begin
                     // Low range returns only the low byte
                     if (io_low_r)
                        O_NB_RDATA <= {24'h000000, rbyte};
                     else if (mb_byte)
                        O_NB_RDATA <= {4{rbyte}};
                     else if (!is_word)
                        O_NB_RDATA <= {2{din_s}};
                     else if (second_r)
                        O_NB_RDATA[31:16] <= din_s;
                     else
                        O_NB_RDATA[15:0] <= din_s;
                  end
                  state_r <= S_NM_REL;
               end
            end
            S_NM_REL:
            begin
               // Wait for XACK to fall before the next cycle or the ACK
               if (!xack_s)
               begin
                  if (!last)
                  begin
                     second_r <= 1'b1;        // Upper half next
                     state_r  <= S_NM_ARB;
                  end
                  else
                  begin
                     // ACK only after every Multibus cycle
                     O_MB_BREQ   <= 1'b0;
                     O_MB_BUSY   <= 1'b0;
                     O_MB_LOCK   <= 1'b0;
                     O_MB_DAT_OE <= 1'b0;
                     O_NB_ACK    <= 1'b1;
                     O_NB_STAT   <= nmb_pkg::STAT_OK;
                     state_r     <= S_IDLE;
                  end
               end
            end
            S_MN_MAP:
            begin
               // Valid entry means a NuBus access
               if (map_valid)
               begin
                  O_NBM_REQ <= 1'b1;
                  state_r   <= S_MN_ARB;
               end
               else
                  state_r <= S_MN_END;        // Not ours, stay silent
            end
            S_MN_ARB:
            begin
               if (I_NBM_GRANT)
               begin
                  O_NBM_START       <= 1'b1;
                  O_NBM_REQ_D.addr  <= nbm_addr;
                  O_NBM_REQ_D.wdata <= {2{mbs_s.dat}};
                  O_NBM_REQ_D.write <= mbs_s.wr;
                  O_NBM_REQ_D.size  <= m_half ? nmb_pkg::SIZE_HALF
                                              : nmb_pkg::SIZE_BYTE;
                  O_NBM_REQ_D.lock  <= mbs_s.lock;
                  state_r           <= S_MN_CYC;
               end
            end
            S_MN_CYC:
            begin
               if (I_NBM_ACK)
               begin
                  // XACK only after the NuBus slave answered
                  O_NBM_REQ    <= mbs_s.lock;
                  O_MBS_DAT    <= lane16(I_NBM_RDATA,
                                         O_NBM_REQ_D.addr[1]);
                  O_MBS_DAT_OE <= mbs_s.rd;
                  O_MBS_XACK   <= 1'b1;
                  state_r      <= S_MN_END;
               end
            end
            S_MN_END:
            begin
               // Buses decouple once the master drops its command
               if (!mbs_cmd)
               begin
                  O_MBS_XACK   <= 1'b0;
                  O_MBS_DAT_OE <= 1'b0;
                  state_r      <= S_IDLE;
               end
            end
         endcase
      end
   end

   // Everything above is plain hardware with no processor path

endmodule

// ===== design/nmb_map_ram.sv
`timescale 1ns/100ps
// Map memory: one write port, one read port, registered read data
module nmb_map_ram
#(
   parameter int W = 24,
   parameter int A = 10
)
(
   input  wire logic         i_clk,
   // Write port
   input  wire logic         i_we,
   input  wire logic [A-1:0] i_waddr,
   input  wire logic [W-1:0] i_wdata,
   // Read port
   input  wire logic [A-1:0] i_raddr,
   output logic      [W-1:0] o_rdata
);

   logic [W-1:0] mem [0:(1<<A)-1];

   // No reset on the array; entries are undefined until loaded
   always_ff @(posedge i_clk)
   begin
      if (i_we)
         mem[i_waddr] <= i_wdata;
      o_rdata <= mem[i_raddr];
   end

endmodule

// ===== design/nmb_pkg.sv
package nmb_pkg;

   // ****************
   // NuBus side encodings
   // ****************
   localparam logic [1:0] SIZE_BYTE  = 2'h0;
   localparam logic [1:0] SIZE_HALF  = 2'h1;
   localparam logic [1:0] SIZE_WORD  = 2'h2;
   localparam logic [1:0] STAT_OK    = 2'h0;
   localparam logic [1:0] STAT_RETRY = 2'h1;   // Try again later
   localparam logic [3:0] SLOT_SPACE = 4'hF;   // Top nibble of slot space
   localparam logic [3:0] SLOT_RST   = 4'h0;   // Default slot number

   // ****************
   // Slot space windows, selected by slot address bits 23:22
   // ****************
   localparam int         WIN_MSB    = 23;
   localparam logic [1:0] WIN_IO_LOW = 2'h2;   // I/O, low byte per word
   localparam logic [1:0] WIN_IO_FUL = 2'h3;   // I/O, full width
   localparam int         IO_LOW_SH  = 2;      // Word index is I/O addr

   // ****************
   // Multibus to NuBus map
   // ****************
   localparam int MAP_IDX_W = 10;
   localparam int MAP_W     = 24;
   localparam int MAP_VALID = 23;
   localparam int PAGE_W    = 14;
   localparam int MB_ADR_W  = 24;

   // ****************
   // Carriers
   // ****************
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        write;
      logic [1:0]  size;
      logic        lock;
   } nmb_nb_req_t;

   typedef struct packed {
      logic                mem_rd;
      logic                mem_wr;
      logic                io_rd;
      logic                io_wr;
   } nmb_mb_cmd_t;

   typedef struct packed {
      logic [MB_ADR_W-1:0] adr;
      logic [15:0]         dat;
      logic                bhe;
      logic                rd;
      logic                wr;
      logic                lock;
   } nmb_mbs_req_t;

endpackage

// ===== tb/nmb_chk.sv
`timescale 1ns/100ps
// ****************
// Port checker for the bus bridge
// ****************
module nmb_chk
#(
   parameter logic [3:0] SLOT = nmb_pkg::SLOT_RST
)
(
   // Clock and reset
   input  wire logic                  I_CLK_SYS,
   input  wire logic                  I_RST,
   // NuBus side
   input  wire logic                  I_NB_START,
   input  wire nmb_pkg::nmb_nb_req_t  I_NB_REQ,
   input  wire logic                  O_NB_ACK,
   input  wire logic [1:0]            O_NB_STAT,
   input  wire logic                  O_NBM_START,
   input  wire logic                  O_NBM_REQ,
   input  wire logic                  I_NBM_GRANT,
   input  wire logic                  I_NBM_ACK,
   // Multibus side
   input  wire logic                  O_MB_BREQ,
   input  wire logic                  O_MB_BUSY,
   input  wire nmb_pkg::nmb_mb_cmd_t  O_MB_CMD,
   input  wire logic                  O_MB_LOCK,
   input  wire nmb_pkg::nmb_mbs_req_t I_MBS,
   input  wire logic                  O_MBS_XACK
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);

   property p_ack_pulse;
      O_NB_ACK |=> !O_NB_ACK;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack too long");
   property p_cmd_owned;
      O_MB_CMD != '0 |-> O_MB_BREQ && O_MB_BUSY;
   endproperty
   a_cmd_owned: assert property (p_cmd_owned)
      else $error("command without bus");
   // A retry may cut in, an OK answer may not
   property p_no_ack_mid;
      O_MB_CMD != '0 |-> !(O_NB_ACK && O_NB_STAT == nmb_pkg::STAT_OK);
   endproperty
   a_no_ack_mid: assert property (p_no_ack_mid)
      else $error("ack mid cycle");
   property p_retry;
      I_NB_START && I_NB_REQ.addr[31:24] == {nmb_pkg::SLOT_SPACE, SLOT}
         && O_MBS_XACK |-> ##[1:2] O_NB_ACK
         && O_NB_STAT == nmb_pkg::STAT_RETRY;
   endproperty
   a_retry: assert property (p_retry)
      else $error("no retry");
   property p_xack_cause;
      $rose(O_MBS_XACK) |-> $past(I_NBM_ACK, 1);
   endproperty
   a_xack_cause: assert property (p_xack_cause)
      else $error("xack without ack");
   property p_start_grant;
      O_NBM_START |-> $past(I_NBM_GRANT) && $past(O_NBM_REQ);
   endproperty
   a_start_grant: assert property (p_start_grant)
      else $error("start without grant");
   property p_lock_busy;
      O_MB_LOCK |-> O_MB_BUSY;
   endproperty
   a_lock_busy: assert property (p_lock_busy)
      else $error("lock outside crossing");
   property p_cmd_onehot;
      $onehot0(O_MB_CMD);
   endproperty
   a_cmd_onehot: assert property (p_cmd_onehot)
      else $error("two commands");
   property p_xack_drop;
      O_MBS_XACK && !I_MBS.rd && !I_MBS.wr |-> ##[1:4] !O_MBS_XACK;
   endproperty
   a_xack_drop: assert property (p_xack_drop)
      else $error("xack held");
endmodule

bind nmb_bridge nmb_chk #(.SLOT(SLOT)) nmb_chk_i
(
   .I_CLK_SYS, .I_RST, .I_NB_START, .I_NB_REQ, .O_NB_ACK, .O_NB_STAT,
   .O_NBM_START, .O_NBM_REQ, .I_NBM_GRANT, .I_NBM_ACK, .O_MB_BREQ,
   .O_MB_BUSY, .O_MB_CMD, .O_MB_LOCK, .I_MBS, .O_MBS_XACK
);

// ===== tb/nmb_partner.sv
`timescale 1ns/100ps
// ****************
// Far side: Multibus arbiter and slave, NuBus arbiter and slave
// ****************
module nmb_partner
(
   // Clock, reset, pace
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   input  wire logic                 i_slow,
   // Multibus master side of the bridge
   input  wire logic                 i_breq,
   input  wire nmb_pkg::nmb_mb_cmd_t i_cmd,
   input  wire logic [23:0]          i_adr,
   input  wire logic                 i_bhe,
   input  wire logic                 i_lock,
   input  wire logic [15:0]          i_dat,
   input  wire logic                 i_oe,
   output logic                      o_grant,
   output logic                      o_xack,
   output logic [15:0]               o_dat,
   // NuBus master side of the bridge
   input  wire logic                 i_req,
   input  wire logic                 i_start,
   input  wire nmb_pkg::nmb_nb_req_t i_nreq,
   output logic                      o_ngrant,
   output logic                      o_ack,
   output logic [31:0]               o_rdata
);
   logic [2:0]           wait_r;
   logic [1:0]           ack_r;
   logic [3:0]           mb_n;
   logic [45:0]          mb_log [16];
   nmb_pkg::nmb_nb_req_t nb_last;
   logic [7:0]           rb;
   logic [15:0]          na;

   // Read data follows the address; lines toggle once released
   assign rb      = i_adr[7:0] ^ 8'h5A;
   assign o_dat   = o_xack ? {rb, rb} : ~{rb, rb};
   assign na      = nb_last.addr[15:0];
   assign o_rdata = o_ack ? {~na, na} : {na, ~na};

   // Grant follows request; xack after a prompt or slow wait
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         {o_grant, o_xack, o_ngrant, o_ack} <= 4'h0;
         wait_r <= 3'h0;
         ack_r  <= 2'h0;
         mb_n   <= 4'h0;
      end
      else
      begin
         o_grant  <= i_breq;
         o_ngrant <= i_req;
         ack_r    <= {ack_r[0], i_start};
         o_ack    <= ack_r[1];
         if (i_cmd == '0)
         begin
            o_xack <= 1'b0;
            wait_r <= 3'h0;
         end
         else if (!o_xack && wait_r >= (i_slow ? 3'h6 : 3'h1))
         begin
            o_xack       <= 1'b1;
            mb_log[mb_n] <= {i_lock, i_bhe, i_cmd, i_adr,
                             i_oe ? i_dat : 16'h0};
            mb_n         <= mb_n + 4'h1;
         end
         else if (!o_xack)
            wait_r <= wait_r + 3'h1;
         if (i_start)
            nb_last <= i_nreq;
      end
   end
endmodule

// ===== tb/test_nmb_bridge.sv
`timescale 1ns/100ps
module test_nmb_bridge;
   logic clk, rst, slow, nb_start, nbm_req, nbm_grant, nbm_start, nbm_ack;
   logic nb_ack, mb_breq, mb_grant, mb_busy, mb_bhe, mb_lock, mb_oe;
   logic mb_xack, mbs_xack, mbs_oe, map_we;
   logic [1:0]            nb_stat;
   logic [31:0]           nb_rdata, nbm_rdata;
   logic [23:0]           mb_adr, map_data;
   logic [15:0]           mb_dat, mb_din, mbs_dat;
   logic [9:0]            map_idx;
   nmb_pkg::nmb_nb_req_t  nb_req, nbm_d;
   nmb_pkg::nmb_mb_cmd_t  mb_cmd;
   nmb_pkg::nmb_mbs_req_t mbs;
   int                    failures, n_checks, base;

   // ****************
   // Clock, design and far side
   // ****************
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   nmb_bridge nmb_bridge_i (.I_CLK_SYS(clk), .I_RST(rst),
      .I_NB_START(nb_start), .I_NB_REQ(nb_req), .O_NB_ACK(nb_ack),
      .O_NB_STAT(nb_stat), .O_NB_RDATA(nb_rdata), .O_NBM_REQ(nbm_req),
      .I_NBM_GRANT(nbm_grant), .O_NBM_START(nbm_start),
      .O_NBM_REQ_D(nbm_d), .I_NBM_ACK(nbm_ack), .I_NBM_RDATA(nbm_rdata),
      .O_MB_BREQ(mb_breq), .I_MB_GRANT(mb_grant), .O_MB_BUSY(mb_busy),
      .O_MB_ADR(mb_adr), .O_MB_BHE(mb_bhe), .O_MB_CMD(mb_cmd),
      .O_MB_LOCK(mb_lock), .O_MB_DAT(mb_dat), .O_MB_DAT_OE(mb_oe),
      .I_MB_DAT(mb_din), .I_MB_XACK(mb_xack), .I_MBS(mbs),
      .O_MBS_XACK(mbs_xack), .O_MBS_DAT(mbs_dat), .O_MBS_DAT_OE(mbs_oe),
      .I_MAP_WE(map_we), .I_MAP_IDX(map_idx), .I_MAP_DATA(map_data));

   nmb_partner nmb_partner_i (.i_clk(clk), .i_rst(rst), .i_slow(slow),
      .i_breq(mb_breq), .i_cmd(mb_cmd), .i_adr(mb_adr), .i_bhe(mb_bhe),
      .i_lock(mb_lock), .i_dat(mb_dat), .i_oe(mb_oe), .o_grant(mb_grant),
      .o_xack(mb_xack), .o_dat(mb_din), .i_req(nbm_req),
      .i_start(nbm_start), .i_nreq(nbm_d), .o_ngrant(nbm_grant),
      .o_ack(nbm_ack), .o_rdata(nbm_rdata));

   // ****************
   // Shared tasks
   // ****************
   task automatic check(input string nm, input logic [71:0] seen,
                        input logic [71:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One NuBus access, waits for the ack
   task automatic nb_io(input logic [31:0] a, input logic [31:0] d,
                        input logic w, input logic [1:0] s,
                        input logic lk);
      @(posedge clk);
      base     = nmb_partner_i.mb_n;
      nb_start <= 1'b1;
      nb_req   <= '{a, d, w, s, lk};
      @(posedge clk);
      nb_start <= 1'b0;
      for (int k = 0; k < 400 && nb_ack !== 1'b1; k++)
         @(negedge clk);
      check("nubus ack", nb_ack, 1'b1);
   endtask

   // Logged Multibus cycle: lock, bhe, command, address, data
   task automatic cyc(input int k, input logic [45:0] exp);
      check("multibus cycle", nmb_partner_i.mb_log[k[3:0]], exp);
   endtask

   task automatic wait_xack(input logic v);
      for (int k = 0; k < 200 && mbs_xack !== v; k++)
         @(negedge clk);
      check("multibus xack", mbs_xack, v);
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_mem_word;
      slow = 1'b1;
      nb_io(32'hF0000100, 32'hA1B2C3D4, 1'b1, nmb_pkg::SIZE_WORD, 1'b1);
      slow = 1'b0;
      check("stat", nb_stat, nmb_pkg::STAT_OK);
      check("count", nmb_partner_i.mb_n, base + 2);
      cyc(base, {2'h3, 4'h4, 24'h000100, 16'hC3D4});
      cyc(base + 1, {2'h3, 4'h4, 24'h000102, 16'hA1B2});
   endtask

   task automatic t_mem_byte;
      nb_io(32'hF0000003, 32'h0, 1'b0, nmb_pkg::SIZE_BYTE, 1'b0);
      cyc(base, {2'h1, 4'h8, 24'h000003, 16'h0});
      check("rdata", nb_rdata, {4{8'h59}});
   endtask

   task automatic t_io_low;
      nb_io(32'hF0800010, 32'h0, 1'b0, nmb_pkg::SIZE_WORD, 1'b0);
      check("count", nmb_partner_i.mb_n, base + 1);
      cyc(base, {2'h0, 4'h2, 24'h000004, 16'h0});
      check("rdata", nb_rdata, 32'h0000005E);
   endtask

   task automatic t_io_full;
      nb_io(32'hF0C00020, 32'h12345678, 1'b1, nmb_pkg::SIZE_WORD, 1'b0);
      cyc(base, {2'h1, 4'h1, 24'h000020, 16'h5678});
      cyc(base + 1, {2'h1, 4'h1, 24'h000022, 16'h1234});
   endtask

   task automatic t_m2n_rd;
      @(posedge clk);
      mbs <= '{24'h00C122, 16'h0, 1'b1, 1'b1, 1'b0, 1'b0};
      wait_xack(1'b1);
      check("mbs dat", {mbs_oe, mbs_dat}, 17'h1BEDD);
      check("nb req", nmb_partner_i.nb_last,
            {32'hAAF34122, 32'h0, 1'b0, nmb_pkg::SIZE_HALF, 1'b0});
      @(posedge clk);
      mbs.rd <= 1'b0;
      wait_xack(1'b0);
   endtask

   task automatic t_collide;
      @(posedge clk);
      mbs <= '{24'h00C123, 16'h5577, 1'b0, 1'b0, 1'b1, 1'b1};
      wait_xack(1'b1);
      nb_io(32'hF0000200, 32'h0, 1'b0, nmb_pkg::SIZE_BYTE, 1'b0);
      check("stat", nb_stat, nmb_pkg::STAT_RETRY);
      check("no cycle", nmb_partner_i.mb_n, base);
      check("nb req", nmb_partner_i.nb_last,
            {32'hAAF34123, 32'h55775577, 1'b1, nmb_pkg::SIZE_BYTE, 1'b1});
      @(posedge clk);
      mbs.wr <= 1'b0;
      wait_xack(1'b0);
      repeat (4) @(negedge clk);
      check("nubus held", nbm_req, 1'b1);
      @(posedge clk);
      mbs.lock <= 1'b0;
      for (int k = 0; k < 20 && nbm_req !== 1'b0; k++)
         @(negedge clk);
      check("nubus freed", nbm_req, 1'b0);
      nb_io(32'hF0000003, 32'h0, 1'b0, nmb_pkg::SIZE_BYTE, 1'b0);
      check("stat", nb_stat, nmb_pkg::STAT_OK);
   endtask

   // ****************
   // Verdict, watchdog and main sequence
   // ****************
   task automatic results;
      if (failures == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      results;
   end

   initial
   begin
      {rst, slow, nb_start, map_we} = 4'h8;
      nb_req   = '0;
      mbs      = '0;
      map_idx  = 10'h003;
      map_data = 24'h82ABCD; // Entry valid, NuBus page 2ABCD
      failures = 0;
      n_checks = 0;
      repeat (5) @(posedge clk);
      rst    <= 1'b0;
      map_we <= 1'b1;
      @(posedge clk);
      map_we <= 1'b0;
      repeat (3) @(posedge clk);
      t_mem_word;
      t_mem_byte;
      t_io_low;
      t_io_full;
      t_m2n_rd;
      t_collide;
      results;
   end
endmodule
